// ---- design/hwls_unit.sv ----
// Purpose: executes half-word and signed byte/half-word loads and stores
// Assumes: memory answers data and fault in the cycle after the request
// Notes:   register port reads answer one cycle after the read strobe
// How it works
// - run only when condition passes flags
// - immediate offset is bits 11:8 and 3:0
// - up bit adds, else subtracts offset
// - pre uses modified base, post uses old
// - pre-indexed writes back only when requested
// - post-indexed writes modified base back unless base is pc
// - S=1 picks signed byte or half load
// - signed byte fills upper bits with bit 7
// - signed half fills upper bits with bit 15
// - unsigned half clears upper sixteen bits
// - little-endian bytes climb from lane 7:0
// - little-endian half: A1 picks upper lanes
// - big-endian bytes descend from lane 31:24
// - big-endian half: A1 picks lower lanes
// - odd half-word address gives undefined result
// - store repeats low half on both halves
// - pc as base reads instruction plus 8
// - stored pc is instruction plus 12
// - fault input takes data abort trap
// - load 1S+1N+1I, pc 2S+2N+1I, store 2N
//
// Implementation choices: the register offsets and the strobed register port.
`timescale 1ns/1ps
`include "hwls_cfg.svh"

module hwls_unit
(
   input  wire logic                   clk_sys,
   input  wire logic                   nrst,
   // instruction issue
   input  wire logic                   instr_valid,
   input  wire logic [31:0]            instr,
   input  wire logic [31:0]            instr_addr,
   input  wire logic [3:0]             flags,
   output logic                        instr_ready_r,
   output logic                        done_r,
   output logic                        illegal_r,
   output logic                        trap_r,
   output logic                        pc_load_valid_r,
   output logic      [31:0]            pc_load_value_r,
   output hwls_pkg::rf_write_type      rf_write_r,
   // memory side
   output hwls_pkg::mem_bus_type       mem_r,
   input  wire logic [31:0]            mem_rdata,
   input  wire logic                   mem_abort,
   // register port
   input  wire logic [7:0]             bus_addr,
   input  wire logic [31:0]            bus_wdata,
   input  wire logic                   bus_wr,
   input  wire logic                   bus_rd,
   output logic      [31:0]            bus_rdata_r
);

   hwls_pkg::state_type    state_r;
   hwls_pkg::state_type    state_nxt;
   hwls_pkg::decode_type   dec_r;
   hwls_pkg::decode_type   dec_in;
   logic                   cond_ok_r;
   logic [31:0]            pc_r;
   logic                   order_big_r;
   logic                   abort_flag_r;
   logic [31:0]            abort_addr_r;
   logic [31:0]            mod_r;
   logic                   wb_en_r;
   logic [31:0]            load_val_r;
   logic [31:0]            q_base;
   logic [31:0]            q_ofs;
   logic [31:0]            q_src;
   logic [31:0]            base_val;
   logic [31:0]            ofs_val;
   logic [31:0]            mod_val;
   logic [31:0]            xfer_addr;
   logic [31:0]            src_val;
   logic                   wb_en;
   logic                   accept;
   logic                   gpr_hit;
   logic                   rf_we;
   logic [3:0]             rf_waddr;
   logic [31:0]            rf_wdata;

   // condition field against N Z C V flags
   function automatic logic cond_pass(input logic [3:0] c, input logic [3:0] f);
      logic n;
      logic z;
      logic cy;
      logic v;
      n  = f[3];
      z  = f[2];
      cy = f[1];
      v  = f[0];
      case (c)
         4'h0:    cond_pass = z;
         4'h1:    cond_pass = !z;
         4'h2:    cond_pass = cy;
         4'h3:    cond_pass = !cy;
         4'h4:    cond_pass = n;
         4'h5:    cond_pass = !n;
         4'h6:    cond_pass = v;
         4'h7:    cond_pass = !v;
         4'h8:    cond_pass = cy && !z;
         4'h9:    cond_pass = !cy || z;
         4'hA:    cond_pass = (n == v);
         4'hB:    cond_pass = (n != v);
         4'hC:    cond_pass = !z && (n == v);
         4'hD:    cond_pass = z || (n != v);
         4'hE:    cond_pass = 1'b1;
         default: cond_pass = 1'b0;
      endcase
   endfunction : cond_pass

   // field split of one instruction word
   function automatic hwls_pkg::decode_type decode(input logic [31:0] w);
      hwls_pkg::decode_type d;
      d.cond  = w[`INS_COND_HI:`INS_COND_LO];
      d.pre   = w[`INS_PRE_BIT];
      d.up    = w[`INS_UP_BIT];
      d.imm   = w[`INS_IMM_BIT];
      d.wb    = w[`INS_WB_BIT];
      d.load  = w[`INS_LOAD_BIT];
      d.sgn   = w[`INS_SIGN_BIT];
      d.half  = w[`INS_HALF_BIT];
      d.rn    = w[`INS_RN_HI:`INS_RN_LO];
      d.rd    = w[`INS_RD_HI:`INS_RD_LO];
      d.rm    = w[`INS_OFSL_HI:`INS_OFSL_LO];
      d.ofs8  = {w[`INS_OFSH_HI:`INS_OFSH_LO], w[`INS_OFSL_HI:`INS_OFSL_LO]};
      // S=H=0 is another class; no signed store
      d.legal = (w[`INS_CLASS_HI:`INS_CLASS_LO] == `INS_CLASS_VAL) && w[`INS_MARK_HI]
                && w[`INS_MARK_LO] && (d.sgn || d.half) && !(d.sgn && !d.load);
      return d;
   endfunction : decode

   // lane steering and extension of loaded data
   function automatic logic [31:0] extract(input logic [31:0] data, input logic [1:0] a,
                                           input logic big, input logic sgn, input logic half);
      logic [15:0] h;
      logic [7:0]  b;
      logic [1:0]  lane;
      h    = ((a[1] ^ big) ? data[31:16] : data[15:0]);
      lane = big ? ~a : a;
      case (lane)
         2'h0:    b = data[7:0];
         2'h1:    b = data[15:8];
         2'h2:    b = data[23:16];
         default: b = data[31:24];
      endcase
      if (half && sgn)
         extract = {{16{h[15]}}, h};
      else if (half)
         extract = {`ZERO_HALF, h};
      else
         extract = {{24{b[7]}}, b};
   endfunction : extract

   assign dec_in  = decode(instr);
   assign accept  = (state_r == hwls_pkg::ST_IDLE) && instr_valid;
   assign gpr_hit = (bus_addr[`GPR_SEL_HI:`GPR_SEL_LO] == `GPR_SEL_VAL);

   // register file; port c follows the store source
   hwls_regfile u_regfile
   (
      .clk_sys  (clk_sys),
      .addr_a   (dec_in.rn),
      .addr_b   (dec_in.rm),
      .addr_c   (dec_in.rd),
      .data_a_r (q_base),
      .data_b_r (q_ofs),
      .data_c_r (q_src),
      .wr_en    (rf_we),
      .wr_addr  (rf_waddr),
      .wr_data  (rf_wdata)
   );

   // address arithmetic, valid in ST_OPS
   always_comb
   begin
      base_val  = (dec_r.rn == `PC_INDEX) ? pc_r + `PC_BASE_ADJ : q_base;
      ofs_val   = dec_r.imm ? {24'h00_0000, dec_r.ofs8} : q_ofs;
      mod_val   = dec_r.up ? base_val + ofs_val : base_val - ofs_val;
      xfer_addr = dec_r.pre ? mod_val : base_val;
      // pc base never writes back
      wb_en     = (!dec_r.pre || dec_r.wb) && (dec_r.rn != `PC_INDEX);
      src_val   = (dec_r.rd == `PC_INDEX) ? pc_r + `PC_STORE_ADJ : q_src;
   end

   // sequencer: N,I,S per load; N,N per store
   always_comb
   begin
      state_nxt = state_r;
      case (state_r)
         hwls_pkg::ST_IDLE:
            if (instr_valid)
               state_nxt = hwls_pkg::ST_OPS;
         hwls_pkg::ST_OPS:
            if (cond_ok_r && dec_r.legal)
               state_nxt = hwls_pkg::ST_XFER;
            else
               state_nxt = hwls_pkg::ST_IDLE;
         hwls_pkg::ST_XFER:
            state_nxt = hwls_pkg::ST_RESP;
         hwls_pkg::ST_RESP:
            if (mem_abort || !dec_r.load)
               state_nxt = hwls_pkg::ST_IDLE;
            else
               state_nxt = hwls_pkg::ST_LDWR;
         hwls_pkg::ST_LDWR:
            if (dec_r.rd == `PC_INDEX)
               state_nxt = hwls_pkg::ST_PC_N;
            else
               state_nxt = hwls_pkg::ST_IDLE;
         hwls_pkg::ST_PC_N:
            state_nxt = hwls_pkg::ST_PC_S;
         hwls_pkg::ST_PC_S:
            state_nxt = hwls_pkg::ST_IDLE;
         default:
            state_nxt = hwls_pkg::ST_IDLE;
      endcase
   end

   // state register
   always_ff @(posedge clk_sys or negedge nrst)
   begin
      if (!nrst)
         state_r <= hwls_pkg::ST_IDLE;
      else
         state_r <= state_nxt;
   end

   // instruction capture at acceptance
   always_ff @(posedge clk_sys or negedge nrst)
   begin
      if (!nrst)
      begin
         dec_r     <= '0;
         cond_ok_r <= 1'b0;
         pc_r      <= `ZERO_WORD;
      end
      else if (accept)
      begin
         dec_r     <= dec_in;
         cond_ok_r <= cond_pass(dec_in.cond, flags);
         pc_r      <= instr_addr;
      end
   end

   // address and write-back bookkeeping
   always_ff @(posedge clk_sys or negedge nrst)
   begin
      if (!nrst)
      begin
         mod_r   <= `ZERO_WORD;
         wb_en_r <= 1'b0;
      end
      else if (state_r == hwls_pkg::ST_OPS)
      begin
         mod_r   <= mod_val;
         wb_en_r <= wb_en;
      end
   end

   // memory request; held only for the cycle types of each step
   always_ff @(posedge clk_sys or negedge nrst)
   begin
      if (!nrst)
         mem_r <= '0;
      else
      begin
         mem_r.req <= 1'b0;
         case (state_nxt)
            hwls_pkg::ST_XFER:
            begin
               mem_r.req   <= 1'b1;
               mem_r.write <= !dec_r.load;
               mem_r.half  <= dec_r.half;
               mem_r.addr  <= xfer_addr;
               mem_r.wdata <= {src_val[15:0], src_val[15:0]};
               mem_r.cycle <= hwls_pkg::CYC_N;
            end
            hwls_pkg::ST_RESP:
               mem_r.cycle <= dec_r.load ? hwls_pkg::CYC_I : hwls_pkg::CYC_N;
            hwls_pkg::ST_LDWR,
            hwls_pkg::ST_PC_S:
               mem_r.cycle <= hwls_pkg::CYC_S;
            hwls_pkg::ST_PC_N:
               mem_r.cycle <= hwls_pkg::CYC_N;
            default:
               mem_r.cycle <= hwls_pkg::CYC_IDLE;
         endcase
      end
   end

   // loaded value capture; memory answers in ST_RESP
   always_ff @(posedge clk_sys or negedge nrst)
   begin
      if (!nrst)
         load_val_r <= `ZERO_WORD;
      else if (state_r == hwls_pkg::ST_RESP)
         load_val_r <= extract(mem_rdata, mem_r.addr[1:0], order_big_r, dec_r.sgn, dec_r.half);
   end

   // one write port: base first, then load dest, so dest wins
   always_comb
   begin
      rf_we    = 1'b0;
      rf_waddr = dec_r.rn;
      rf_wdata = mod_r;
      if (state_r == hwls_pkg::ST_RESP)
         rf_we = wb_en_r && !mem_abort;
      else if (state_r == hwls_pkg::ST_LDWR)
      begin
         rf_we    = (dec_r.rd != `PC_INDEX);
         rf_waddr = dec_r.rd;
         rf_wdata = load_val_r;
      end
      else if ((state_r == hwls_pkg::ST_IDLE) && !instr_valid && bus_wr && gpr_hit)
      begin
         rf_we    = 1'b1;
         rf_waddr = bus_addr[`GPR_IDX_HI:`GPR_IDX_LO];
         rf_wdata = bus_wdata;
      end
   end

   // mirror of register file writes for observers
   always_ff @(posedge clk_sys or negedge nrst)
   begin
      if (!nrst)
         rf_write_r <= '0;
      else
      begin
         rf_write_r.valid <= rf_we;
         rf_write_r.index <= rf_waddr;
         rf_write_r.data  <= rf_wdata;
      end
   end

   // completion, trap and pc load pulses
   always_ff @(posedge clk_sys or negedge nrst)
   begin
      if (!nrst)
      begin
         done_r          <= 1'b0;
         illegal_r       <= 1'b0;
         trap_r          <= 1'b0;
         pc_load_valid_r <= 1'b0;
         pc_load_value_r <= `ZERO_WORD;
      end
      else
      begin
         done_r          <= (state_r != hwls_pkg::ST_IDLE) && (state_nxt == hwls_pkg::ST_IDLE);
         illegal_r       <= (state_r == hwls_pkg::ST_OPS) && cond_ok_r && !dec_r.legal;
         trap_r          <= (state_r == hwls_pkg::ST_RESP) && mem_abort;
         pc_load_valid_r <= (state_r == hwls_pkg::ST_LDWR) && (dec_r.rd == `PC_INDEX);
         if ((state_r == hwls_pkg::ST_LDWR) && (dec_r.rd == `PC_INDEX))
            pc_load_value_r <= load_val_r;
      end
   end

   // ready again once idle; one instruction at a time
   always_ff @(posedge clk_sys or negedge nrst)
   begin
      if (!nrst)
         instr_ready_r <= 1'b0;
      else
         instr_ready_r <= (state_nxt == hwls_pkg::ST_IDLE) && !accept;
   end

   // control register: byte order select
   always_ff @(posedge clk_sys or negedge nrst)
   begin
      if (!nrst)
         order_big_r <= `CTRL_RESET;
      else if (bus_wr && (bus_addr == `REG_CTRL))
         order_big_r <= bus_wdata[`CTRL_ORDER_BIT];
   end

   // sticky abort flag; a new abort beats a clearing write
   always_ff @(posedge clk_sys or negedge nrst)
   begin
      if (!nrst)
      begin
         abort_flag_r <= 1'b0;
         abort_addr_r <= `ZERO_WORD;
      end
      else if ((state_r == hwls_pkg::ST_RESP) && mem_abort)
      begin
         abort_flag_r <= 1'b1;
         abort_addr_r <= mem_r.addr;
      end
      else if (bus_wr && (bus_addr == `REG_STATUS) && bus_wdata[`STAT_ABORT_BIT])
         abort_flag_r <= 1'b0;
   end

   // read data, valid the cycle after bus_rd only
   always_ff @(posedge clk_sys or negedge nrst)
   begin
      if (!nrst)
         bus_rdata_r <= `ZERO_WORD;
      else if (bus_rd)
      begin
         bus_rdata_r <= `ZERO_WORD;
         case (bus_addr)
            `REG_CTRL:
               bus_rdata_r[`CTRL_ORDER_BIT] <= order_big_r;
            `REG_STATUS:
            begin
               bus_rdata_r[`STAT_BUSY_BIT]  <= (state_r != hwls_pkg::ST_IDLE);
               bus_rdata_r[`STAT_ABORT_BIT] <= abort_flag_r;
            end
            `REG_ABORT_ADDR:
               bus_rdata_r <= abort_addr_r;
            default:
               bus_rdata_r <= `ZERO_WORD; // unmapped, gpr window
         endcase
      end
      else
         bus_rdata_r <= `ZERO_WORD;
   end

endmodule : hwls_unit

// ---- design/hwls_cfg.svh ----
// Purpose: named constants for the half-word / signed load-store unit
// Assumes: included by bare name from the package and the hwls_unit module
// Notes:   definitions only, guarded against double inclusion
`ifndef HWLS_CFG_SVH
`define HWLS_CFG_SVH

// instruction field positions
`define INS_COND_HI     31
`define INS_COND_LO     28
`define INS_CLASS_HI    27
`define INS_CLASS_LO    25
`define INS_PRE_BIT     24
`define INS_UP_BIT      23
`define INS_IMM_BIT     22
`define INS_WB_BIT      21
`define INS_LOAD_BIT    20
`define INS_RN_HI       19
`define INS_RN_LO       16
`define INS_RD_HI       15
`define INS_RD_LO       12
`define INS_OFSH_HI     11
`define INS_OFSH_LO     8
`define INS_MARK_HI     7
`define INS_SIGN_BIT    6
`define INS_HALF_BIT    5
`define INS_MARK_LO     4
`define INS_OFSL_HI     3
`define INS_OFSL_LO     0
`define INS_CLASS_VAL   3'h0

// program counter handling
`define PC_INDEX        4'hF
`define PC_BASE_ADJ     32'h0000_0008
`define PC_STORE_ADJ    32'h0000_000C

// register port map (byte addresses)
`define REG_CTRL        8'h00
`define REG_STATUS      8'h04
`define REG_ABORT_ADDR  8'h08
`define GPR_SEL_HI      7
`define GPR_SEL_LO      6
`define GPR_SEL_VAL     2'h1
`define GPR_IDX_HI      5
`define GPR_IDX_LO      2

// register fields and reset values
`define CTRL_ORDER_BIT  0
`define STAT_BUSY_BIT   1'h0
`define STAT_ABORT_BIT  1'h1
`define CTRL_RESET      1'h0
`define ZERO_WORD       32'h0000_0000
`define ZERO_HALF       16'h0000

`endif

// ---- design/hwls_pkg.sv ----
// Purpose: shared types of the half-word / signed load-store unit
// Assumes: constants come from hwls_cfg.svh
// Notes:   states, memory cycle kinds and carrier structs
`include "hwls_cfg.svh"

package hwls_pkg;

   typedef enum logic [2:0]
   {
      ST_IDLE  = 3'b000,
      ST_OPS   = 3'b001,
      ST_XFER  = 3'b010,
      ST_RESP  = 3'b011,
      ST_LDWR  = 3'b100,
      ST_PC_N  = 3'b101,
      ST_PC_S  = 3'b110
   } state_type;

   typedef enum logic [1:0]
   {
      CYC_IDLE = 2'b00,
      CYC_N    = 2'b01,
      CYC_S    = 2'b10,
      CYC_I    = 2'b11
   } cycle_type;

   typedef struct packed
   {
      logic        req;
      logic        write;
      logic        half;
      logic [31:0] addr;
      logic [31:0] wdata;
      cycle_type   cycle;
   } mem_bus_type;

   typedef struct packed
   {
      logic        valid;
      logic [3:0]  index;
      logic [31:0] data;
   } rf_write_type;

   typedef struct packed
   {
      logic [3:0]  cond;
      logic        legal;
      logic        pre;
      logic        up;
      logic        imm;
      logic        wb;
      logic        load;
      logic        sgn;
      logic        half;
      logic [3:0]  rn;
      logic [3:0]  rd;
      logic [3:0]  rm;
      logic [7:0]  ofs8;
   } decode_type;

endpackage : hwls_pkg

// ---- design/hwls_regfile.sv ----
// Purpose: sixteen-word register file with three registered read ports
// Assumes: one synchronous write port, write and read on clk_sys
// Notes:   read data appear one cycle after the address; no reset on storage
`timescale 1ns/1ps

module hwls_regfile
(
   input  wire logic        clk_sys,
   input  wire logic [3:0]  addr_a,
   input  wire logic [3:0]  addr_b,
   input  wire logic [3:0]  addr_c,
   output logic      [31:0] data_a_r,
   output logic      [31:0] data_b_r,
   output logic      [31:0] data_c_r,
   input  wire logic        wr_en,
   input  wire logic [3:0]  wr_addr,
   input  wire logic [31:0] wr_data
);

   logic [31:0] mem_r [16];

   // storage write
   always_ff @(posedge clk_sys)
   begin
      if (wr_en)
         mem_r[wr_addr] <= wr_data;
   end

   // registered reads; old data on a same-cycle write
   always_ff @(posedge clk_sys)
   begin
      data_a_r <= mem_r[addr_a];
      data_b_r <= mem_r[addr_b];
      data_c_r <= mem_r[addr_c];
   end

endmodule : hwls_regfile

// ---- dv/hwls_mem.sv ----
// Purpose: memory system model facing the load-store unit
// Assumes: answers one cycle after a request
// Notes:   idle data bus toggles
`timescale 1ns/1ps

module hwls_mem
(
   input  wire logic                  clk_sys,
   input  wire hwls_pkg::mem_bus_type mem_r,
   input  wire logic                  big,
   input  wire logic                  fault,
   output logic      [31:0]           mem_rdata,
   output logic                       mem_abort
);
   logic [31:0] ram [64];

   initial
   begin
      mem_rdata = 32'h0000_0000;
      foreach (ram[k])
         ram[k] = 32'h5A3C_96E1 ^ (k * 32'h0101_8423);
   end

   // one-cycle answer; a faulted store never reaches the array
   always @(posedge clk_sys)
   begin
      mem_abort <= mem_r.req & fault;
      mem_rdata <= (mem_r.req & !mem_r.write) ? ram[mem_r.addr[7:2]] : ~mem_rdata;
      if (mem_r.req & mem_r.write & !fault)
      begin
         if (mem_r.addr[1] ^ big)
            ram[mem_r.addr[7:2]][31:16] <= mem_r.wdata[31:16];
         else
            ram[mem_r.addr[7:2]][15:0] <= mem_r.wdata[15:0];
      end
   end
endmodule : hwls_mem

// ---- dv/hwls_unit_properties.sv ----
// Purpose: port assertions for the load-store unit
// Assumes: one-cycle memory answer
// Notes:   bound into hwls_unit at the foot
`timescale 1ns/1ps

module hwls_unit_chk
(
   input wire logic                   clk_sys,
   input wire logic                   nrst,
   input wire logic                   done_r,
   input wire logic                   illegal_r,
   input wire logic                   trap_r,
   input wire logic                   pc_load_valid_r,
   input wire hwls_pkg::rf_write_type rf_write_r,
   input wire hwls_pkg::mem_bus_type  mem_r,
   input wire logic                   mem_abort
);
   default clocking @(posedge clk_sys); endclocking
   default disable iff (!nrst);

   // cycle kinds and completion timing
   a_req_is_n: assert property (mem_r.req |-> mem_r.cycle == hwls_pkg::CYC_N)
      else $error("req not N");
   a_load_seq: assert property (mem_r.req && !mem_r.write ##1 !mem_abort |->
      mem_r.cycle == hwls_pkg::CYC_I ##1 mem_r.cycle == hwls_pkg::CYC_S) else $error("load order");
   a_store_nn: assert property (mem_r.req && mem_r.write |=> mem_r.cycle == hwls_pkg::CYC_N)
      else $error("store order");
   a_store_done: assert property (mem_r.req && mem_r.write |-> ##2 done_r)
      else $error("store late");
   a_load_done: assert property (mem_r.req && !mem_r.write ##1 !mem_abort |-> ##2 (done_r || pc_load_valid_r))
      else $error("load late");
   a_pc_done: assert property (pc_load_valid_r |-> ##2 done_r)
      else $error("pc late");
   // store data replication
   a_store_dup: assert property (mem_r.req && mem_r.write |-> mem_r.wdata[31:16] == mem_r.wdata[15:0])
      else $error("halves differ");
   // abort stays restartable
   a_abort_trap: assert property (mem_r.req ##1 mem_abort |=> trap_r && done_r)
      else $error("no trap");
   a_abort_quiet: assert property (mem_r.req ##1 mem_abort |=> !rf_write_r.valid [*2])
      else $error("write after abort");
   a_trap_cause: assert property (trap_r |-> $past(mem_abort) && $past(mem_r.req, 2))
      else $error("stray trap");
   a_bad_done: assert property (illegal_r |-> done_r && !mem_r.req)
      else $error("illegal access");

   c_load: cover property (mem_r.req && !mem_r.write);
   c_store: cover property (mem_r.req && mem_r.write);
   c_trap: cover property (trap_r);
   c_pc: cover property (pc_load_valid_r);
endmodule : hwls_unit_chk

bind hwls_unit hwls_unit_chk u_chk
(
   .clk_sys(clk_sys), .nrst(nrst), .done_r(done_r), .illegal_r(illegal_r), .trap_r(trap_r),
   .pc_load_valid_r(pc_load_valid_r), .rf_write_r(rf_write_r), .mem_r(mem_r), .mem_abort(mem_abort)
);

// ---- dv/halfword_signed_load_store_unit_test.sv ----
// Purpose: self-checking bench for the load-store unit
// Assumes: hwls_mem model as memory
// Notes:   registers are preloaded through the gpr window
`timescale 1ns/1ps

module halfword_signed_load_store_unit_test;
   logic                   clk_sys = 0, nrst = 0, instr_valid = 0, bus_wr = 0, bus_rd = 0;
   logic                   big = 0, fault = 0, instr_ready_r, done_r, illegal_r, trap_r, pc_load_valid_r;
   logic                   mem_abort, c_go, p, u, i, w, l, s, h;
   logic [31:0]            instr = '0, instr_addr = '0, bus_wdata = '0, ia, xa, r, rd_v;
   logic [31:0]            mem_rdata, bus_rdata_r, pc_load_value_r, lfsr = 32'd3841, gpr [16];
   logic [3:0]             flags = '0, c, f, rn, rd, rm;
   logic [7:0]             bus_addr = '0, o;
   logic [2:0]             kinds [4] = '{3'b101, 3'b001, 3'b110, 3'b111};
   hwls_pkg::rf_write_type rf_write_r;
   hwls_pkg::mem_bus_type  mem_r;
   int                     n_mismatch = 0, total_checks = 0, n;

   always #2 clk_sys = ~clk_sys;

   hwls_unit uut
   (
      .clk_sys(clk_sys), .nrst(nrst), .instr_valid(instr_valid), .instr(instr), .instr_addr(instr_addr),
      .flags(flags), .instr_ready_r(instr_ready_r), .done_r(done_r), .illegal_r(illegal_r), .trap_r(trap_r),
      .pc_load_valid_r(pc_load_valid_r), .pc_load_value_r(pc_load_value_r), .rf_write_r(rf_write_r),
      .mem_r(mem_r), .mem_rdata(mem_rdata), .mem_abort(mem_abort), .bus_addr(bus_addr),
      .bus_wdata(bus_wdata), .bus_wr(bus_wr), .bus_rd(bus_rd), .bus_rdata_r(bus_rdata_r)
   );

   hwls_mem mem
   (
      .clk_sys(clk_sys), .mem_r(mem_r), .big(big), .fault(fault), .mem_rdata(mem_rdata), .mem_abort(mem_abort)
   );

   function automatic logic [31:0] rnd();
      repeat (32) lfsr = {lfsr[30:0], lfsr[31] ^ lfsr[21] ^ lfsr[1] ^ lfsr[0]};
      return lfsr;
   endfunction : rnd

   // condition code against n z c v
   function automatic logic cond_ok(logic [3:0] cc, logic [3:0] fl);
      logic [7:0] t;
      t = {1'b1, !fl[2] & (fl[3] == fl[0]), fl[3] == fl[0], fl[1] & !fl[2], fl[0], fl[3], fl[1], fl[2]};
      return t[cc[3:1]] ^ cc[0];
   endfunction : cond_ok

   // lane pick and extension
   function automatic logic [31:0] ld_exp(logic [31:0] wd, logic [1:0] a);
      logic [15:0] hw;
      logic [7:0]  b;
      hw = (a[1] ^ big) ? wd[31:16] : wd[15:0];
      b = 8'(wd >> (8 * (big ? 3 - a : a)));
      if (!h)
         return {{24{b[7]}}, b};
      return {{16{s & hw[15]}}, hw};
   endfunction : ld_exp

   task automatic check(string what, logic [35:0] exp, logic [35:0] got);
      total_checks++;
      if (got !== exp)
      begin
         n_mismatch++;
         $display("FAIL %s expected %h seen %h", what, exp, got);
      end
   endtask : check

   task automatic tally_and_finish();
      $display("checks %0d mismatches %0d", total_checks, n_mismatch);
      if (n_mismatch == 0 && total_checks > 0)
         $display("NO MISMATCHES");
      else
         $display("MISMATCHES SEEN");
      $finish;
   endtask : tally_and_finish

   task automatic bus_put(logic [7:0] a, logic [31:0] d);
      @(posedge clk_sys);
      bus_wr <= 1;
      bus_addr <= a;
      bus_wdata <= d;
      @(posedge clk_sys);
      bus_wr <= 0;
   endtask : bus_put

   task automatic bus_get(logic [7:0] a);
      @(posedge clk_sys);
      bus_rd <= 1;
      bus_addr <= a;
      @(posedge clk_sys);
      bus_rd <= 0;
      #1 rd_v = bus_rdata_r;
   endtask : bus_get

   // halves stay even; odd address undefined
   task automatic setr(logic [3:0] k, logic [31:0] v);
      v[0] = v[0] & !h;
      gpr[k] = v;
      bus_put(8'h40 + {2'h0, k, 2'h0}, v);
   endtask : setr

   task automatic exec();
      logic [31:0] base, ofs, md, sv, wd;
      logic [35:0] exp_q[$], got_q[$];
      logic        act, hit, tr, il;
      int          k, lat;
      c_go = cond_ok(c, f);
      act = c_go & (l | !s) & (s | h);
      base = rn == 4'hF ? ia + 32'h0000_0008 : gpr[rn];
      ofs = i ? {24'h0, o} : gpr[rm];
      md = u ? base + ofs : base - ofs;
      xa = p ? md : base;
      sv = rd == 4'hF ? ia + 32'h0000_000C : gpr[rd];
      {hit, tr, il, wd} = '0;
      for (k = 0; k < 20 && !instr_ready_r; k++)
         @(posedge clk_sys);
      @(posedge clk_sys);
      instr_valid <= 1;
      flags <= f;
      instr_addr <= ia;
      instr <= {c, 3'h0, p, u, i, w, l, rn, rd, i ? o[7:4] : 4'h0, 1'b1, s, h, 1'b1, i ? o[3:0] : rm};
      @(posedge clk_sys);
      instr_valid <= 0;
      for (k = 1; k < 12; k++)
      begin
         @(posedge clk_sys);
         #1;
         if (mem_r.req)
         begin
            hit = 1;
            wd = mem.ram[xa[7:2]];
            check("addr", xa, mem_r.addr);
            check("kind", {!l, h}, {mem_r.write, mem_r.half});
            if (!l) check("wdata", {2{sv[15:0]}}, mem_r.wdata);
         end
         if (rf_write_r.valid && rf_write_r.index != 4'hF)
            got_q.push_back({rf_write_r.index, rf_write_r.data});
         tr |= trap_r;
         il |= illegal_r;
         if (done_r)
            break;
      end
      if (k == 12)
      begin
         n_mismatch++;
         tally_and_finish();
      end
      lat = !act ? 1 : (!l | fault) ? 3 : rd == 4'hF ? 6 : 4;
      check("latency", lat, k);
      check("access", act, hit);
      check("trap", act & fault, tr);
      check("illegal", c_go & !act, il);
      if (act & !fault & (w | !p) & rn != 4'hF)
         exp_q.push_back({rn, md});
      if (act & !fault & l & rd != 4'hF)
         exp_q.push_back({rd, ld_exp(wd, xa[1:0])});
      if (act & !fault & l & rd == 4'hF)
         check("pc", ld_exp(wd, xa[1:0]), pc_load_value_r);
      check("writes", exp_q.size(), got_q.size());
      foreach (exp_q[j])
         check("regfile", exp_q[j], got_q[j]);
   endtask : exec

   initial
   begin
      repeat (8) @(posedge clk_sys);
      nrst <= 1;
      foreach (kinds[j])
      begin
         bus_get(8'h00 + 8'(4 * j));
         check("reg reset", 32'h0000_0000, rd_v);
      end
      $display("register test done");
      for (n = 0; n < 300; n++)
      begin
         r = rnd();
         big = r[0];
         bus_put(8'h00, {31'h0, r[0]});
         fault = &r[3:1];
         {l, s, h} = kinds[r[5:4]];
         if (&r[8:6])
            {l, s, h} = {1'b0, r[9], r[9]};
         {rn, rd, c, f} = r[25:10];
         rm = r[29:26] == 4'hF ? 4'h0 : r[29:26];
         c = c == 4'hF ? 4'hE : c;
         p = r[30] | rn == 4'hF;
         u = r[31];
         r = rnd();
         {i, w} = r[1:0];
         o = r[9:2] & {7'h7F, !h};
         ia = r & 32'hFFFF_FFFC;
         setr(rm, rnd());
         setr(rn, rnd());
         setr(rd, rnd());
         exec();
      end
      $display("random test done");
      // directed abort, sticky flag
      bus_put(8'h04, 32'h0000_0002);
      {fault, l, s, h, c, rn, rd, p, i, w, o} = {4'b1101, 4'hE, 4'h1, 4'h2, 3'b111, 8'h10};
      setr(4'h1, 32'h0000_1000);
      exec();
      fault = 0;
      bus_get(8'h04);
      check("abort flag", 32'h0000_0002, rd_v);
      bus_get(8'h08);
      check("abort addr", xa, rd_v);
      bus_put(8'h04, 32'h0000_0002);
      bus_get(8'h04);
      check("abort clear", 32'h0000_0000, rd_v);
      $display("abort test done");
      tally_and_finish();
   end
endmodule : halfword_signed_load_store_unit_test
